// [verilog/lssc_top.sv]
`timescale 1ns/1ps

module lssc_top
  import lssc_pkg::*;
#(
  parameter int TICK_CYCLES = BASE_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_coil_out_a,
  output logic o_coil_out_a_oe,
  output logic o_coil_out_b,
  output logic o_coil_out_b_oe,
  output logic o_coil_out_c,
  output logic o_coil_out_c_oe,
  output logic o_coil_or_shutter_out_d,
  output logic o_coil_or_shutter_out_d_oe,
  output logic o_shutter_out_e,
  output logic o_shutter_out_e_oe,
  output logic o_const_current_mode,
  output logic [3:0] o_current_code,
  output logic [8:0] o_current_ma,
  output logic o_sequence_busy_flag
);

  // =========================================================
  // decode helpers

  // hold length in step periods for the 3-bit hold code
  function automatic logic [7:0] hold_pulses(input logic [2:0] code);
    logic [7:0] p;
    p = 8'h01;
    case (code)
      3'h0: p = 8'h01;
      3'h1: p = 8'h02;
      3'h2: p = 8'h04;
      3'h3: p = 8'h05;
      3'h4: p = 8'h08;
      3'h5: p = 8'h10;
      3'h6: p = 8'h20;
      default: p = 8'h01;
    endcase
    return p;
  endfunction : hold_pulses

  // eight-state 1-2 phase table; even entries form the 2-phase walk
  function automatic logic [3:0] coil_pattern(input logic [2:0] idx);
    logic [3:0] p;
    p = 4'b1010;
    case (idx)
      3'h0: p = 4'b1010;
      3'h1: p = 4'b0010;
      3'h2: p = 4'b0110;
      3'h3: p = 4'b0100;
      3'h4: p = 4'b0101;
      3'h5: p = 4'b0001;
      3'h6: p = 4'b1001;
      default: p = 4'b1000;
    endcase
    return p;
  endfunction : coil_pattern

  // period of one step in base ticks
  function automatic logic [3:0] step_ms(input logic home, input logic exc12);
    logic [3:0] m;
    m = AF_STEP_MS_2PH;
    if (home)
    begin
      m = exc12 ? HOME_STEP_MS_12PH : HOME_STEP_MS_2PH;
    end
    else
    begin
      m = exc12 ? AF_STEP_MS_12PH : AF_STEP_MS_2PH;
    end
    return m;
  endfunction : step_ms

  // =========================================================
  // state and tick

  lssc_state_t st;
  lssc_state_t next_st;
  logic tick;
  logic start_now;
  logic busy;
  logic [7:0] step_total;
  logic [2:0] phase_inc;
  logic [3:0] coils;

  assign busy = (st.seq != SEQ_IDLE);

  // restart keeps the first period a full one after a start
  lssc_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_restart(start_now),
    .o_tick(tick)
  );

  // programmed step total, twice the code plus two, plus optional 64-step extension
  always_comb
  begin
    step_total = {2'b00, st.step_code, 1'b0} + 8'h02;
    if (st.plus64)
    begin
      step_total = step_total + STEP_EXTRA;
    end
  end

  assign start_now = i_wr_en && (i_addr == ADDR_STEP_CMD) && !busy
    && (i_wdata[STEP_AF_RUN_BIT] || st.home_en);
  assign phase_inc = st.exc_12 ? 3'h1 : 3'h2;
  assign coils = coil_pattern(st.phase);

  // =========================================================
  // next state
  always_comb
  begin
    next_st = st;

    // register writes; sequence settings are frozen while busy
    if (i_wr_en)
    begin
      if (i_addr == ADDR_STEP_CMD)
      begin
        if (!busy)
        begin
          next_st.dir = i_wdata[STEP_DIR_BIT];
          next_st.autofocus_run_enable = i_wdata[STEP_AF_RUN_BIT];
          next_st.af_counter_rst_off = i_wdata[STEP_CNT_RST_BIT];
          next_st.step_code = i_wdata[STEP_CODE_LSB +: 5];
        end
      end
      else if (i_addr == ADDR_SEQ_OPTS)
      begin
        if (!busy)
        begin
          next_st.hold_code = i_wdata[OPT_HOLD_LSB +: 3];
          next_st.exc_12 = i_wdata[OPT_EXC_BIT];
          next_st.home_en = i_wdata[OPT_HOME_EN_BIT];
          next_st.plus64 = i_wdata[OPT_PLUS64_BIT];
        end
      end
      else if (i_addr == ADDR_BRIDGE)
      begin
        next_st.br_dir = i_wdata[BR_DIR_LSB +: 2];
        next_st.br_en = i_wdata[BR_EN_BIT];
      end
      else if (i_addr == ADDR_CURRENT)
      begin
        next_st.cur_code = i_wdata[CUR_CODE_LSB +: 4];
      end
    end

    // register reads, unmapped addresses answer zero
    if (i_rd_en)
    begin
      if (i_addr == ADDR_STEP_CMD)
      begin
        next_st.rdata = {st.step_code, st.af_counter_rst_off, st.autofocus_run_enable, st.dir};
      end
      else if (i_addr == ADDR_SEQ_OPTS)
      begin
        next_st.rdata = {busy, 1'b0, st.plus64, st.home_en, st.exc_12, st.hold_code};
      end
      else if (i_addr == ADDR_BRIDGE)
      begin
        next_st.rdata = {5'h00, st.br_en, st.br_dir};
      end
      else if (i_addr == ADDR_CURRENT)
      begin
        next_st.rdata = {4'h0, st.cur_code};
      end
      else
      begin
        next_st.rdata = RST_REG;
      end
    end

    // sequencer: hold, step run, equal hold, then idle
    case (st.seq)
      SEQ_IDLE:
      begin
        if (start_now)
        begin
          next_st.seq = SEQ_PRE_HOLD;
          next_st.seq_home = st.home_en;
          next_st.period_ms = step_ms(st.home_en, st.exc_12);
          next_st.ms_left = step_ms(st.home_en, st.exc_12);
          next_st.pulse_left = hold_pulses(st.hold_code);
          next_st.phase = RST_PHASE;
        end
      end
      SEQ_PRE_HOLD:
      begin
        if (tick)
        begin
          if (st.ms_left == 4'h1)
          begin
            next_st.ms_left = st.period_ms;
            if (st.pulse_left == 8'h01)
            begin
              next_st.seq = SEQ_STEP;
              next_st.pulse_left = step_total;
            end
            else
            begin
              next_st.pulse_left = st.pulse_left - 8'h01;
            end
          end
          else
          begin
            next_st.ms_left = st.ms_left - 4'h1;
          end
        end
      end
      SEQ_STEP:
      begin
        if (tick)
        begin
          if (st.ms_left == 4'h1)
          begin
            next_st.ms_left = st.period_ms;
            next_st.phase = st.dir ? st.phase - phase_inc : st.phase + phase_inc;
            if (st.pulse_left == 8'h01)
            begin
              next_st.seq = SEQ_POST_HOLD;
              next_st.pulse_left = hold_pulses(st.hold_code);
            end
            else
            begin
              next_st.pulse_left = st.pulse_left - 8'h01;
            end
          end
          else
          begin
            next_st.ms_left = st.ms_left - 4'h1;
          end
        end
      end
      SEQ_POST_HOLD:
      begin
        if (tick)
        begin
          if (st.ms_left == 4'h1)
          begin
            next_st.ms_left = st.period_ms;
            if (st.pulse_left == 8'h01)
            begin
              next_st.seq = SEQ_IDLE;
            end
            else
            begin
              next_st.pulse_left = st.pulse_left - 8'h01;
            end
          end
          else
          begin
            next_st.ms_left = st.ms_left - 4'h1;
          end
        end
      end
      default:
      begin
        next_st.seq = SEQ_IDLE;
      end
    endcase

    // =========================================================
    // pin drive; the sequencer owns the shared d pin while it runs
    next_st.pin_out = '0;
    next_st.pin_oe = '0;
    next_st.cc_mode = 1'b0;
    if (busy)
    begin
      next_st.pin_out.a = coils[3];
      next_st.pin_out.b = coils[2];
      next_st.pin_out.c = coils[1];
      next_st.pin_out.d = coils[0];
      next_st.pin_oe.a = 1'b1;
      next_st.pin_oe.b = 1'b1;
      next_st.pin_oe.c = 1'b1;
      next_st.pin_oe.d = 1'b1;
    end
    else if (st.br_en)
    begin
      case (st.br_dir)
        BR_FWD:
        begin
          next_st.pin_out.d = 1'b1;
          next_st.pin_oe.d = 1'b1;
          next_st.pin_oe.e = 1'b1;
          next_st.cc_mode = 1'b1;
        end
        BR_REV:
        begin
          next_st.pin_out.e = 1'b1;
          next_st.pin_oe.d = 1'b1;
          next_st.pin_oe.e = 1'b1;
          next_st.cc_mode = 1'b1;
        end
        BR_BRAKE:
        begin
          next_st.pin_oe.d = 1'b1;
          next_st.pin_oe.e = 1'b1;
        end
        default:
        begin
          next_st.pin_oe.d = 1'b0;
        end
      endcase
    end

    // current set point in mA for the analog regulator
    next_st.cur_ma = CUR_MA_MAX - 9'(CUR_MA_STEP * {5'h00, st.cur_code});
  end

  // =========================================================
  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      st <= '0;
      st.seq <= SEQ_IDLE;
      st.phase <= RST_PHASE;
      st.rdata <= RST_REG;
      st.cur_ma <= CUR_MA_MAX;
    end
    else
    begin
      st <= next_st;
    end
  end

  // =========================================================
  // outputs
  assign o_rdata = st.rdata;
  assign o_coil_out_a = st.pin_out.a;
  assign o_coil_out_a_oe = st.pin_oe.a;
  assign o_coil_out_b = st.pin_out.b;
  assign o_coil_out_b_oe = st.pin_oe.b;
  assign o_coil_out_c = st.pin_out.c;
  assign o_coil_out_c_oe = st.pin_oe.c;
  assign o_coil_or_shutter_out_d = st.pin_out.d;
  assign o_coil_or_shutter_out_d_oe = st.pin_oe.d;
  assign o_shutter_out_e = st.pin_out.e;
  assign o_shutter_out_e_oe = st.pin_oe.e;
  assign o_const_current_mode = st.cc_mode;
  assign o_current_code = st.cur_code;
  assign o_current_ma = st.cur_ma;
  assign o_sequence_busy_flag = busy;

endmodule : lssc_top

// [verilog/lssc_pkg.sv]
package lssc_pkg;

  // =========================================================
  // register addresses
  localparam logic [7:0] ADDR_STEP_CMD = 8'h00;
  localparam logic [7:0] ADDR_SEQ_OPTS = 8'h01;
  localparam logic [7:0] ADDR_BRIDGE = 8'h02;
  localparam logic [7:0] ADDR_CURRENT = 8'h03;

  // =========================================================
  // field positions
  localparam int STEP_DIR_BIT = 0;
  localparam int STEP_AF_RUN_BIT = 1;
  localparam int STEP_CNT_RST_BIT = 2;
  localparam int STEP_CODE_LSB = 3;
  localparam int OPT_HOLD_LSB = 0;
  localparam int OPT_EXC_BIT = 3;
  localparam int OPT_HOME_EN_BIT = 4;
  localparam int OPT_PLUS64_BIT = 5;
  localparam int OPT_BUSY_BIT = 7;
  localparam int BR_DIR_LSB = 0;
  localparam int BR_EN_BIT = 2;
  localparam int CUR_CODE_LSB = 0;

  // =========================================================
  // values after reset
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] RST_PHASE = 3'h0;

  // =========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BASE_TICK_NS = 1000000;
  localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [3:0] AF_STEP_MS_2PH = 4'h2;
  localparam logic [3:0] AF_STEP_MS_12PH = 4'h1;
  localparam logic [3:0] HOME_STEP_MS_2PH = 4'hA;
  localparam logic [3:0] HOME_STEP_MS_12PH = 4'h5;

  // =========================================================
  // step counts and current
  localparam logic [7:0] STEP_EXTRA = 8'h40;
  localparam logic [8:0] CUR_MA_MAX = 9'h104;
  localparam logic [8:0] CUR_MA_STEP = 9'h00A;

  // =========================================================
  // bridge drive codes
  localparam logic [1:0] BR_STANDBY = 2'h0;
  localparam logic [1:0] BR_FWD = 2'h1;
  localparam logic [1:0] BR_REV = 2'h2;
  localparam logic [1:0] BR_BRAKE = 2'h3;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PRE_HOLD = 2'b01,
    SEQ_STEP = 2'b11,
    SEQ_POST_HOLD = 2'b10
  } lssc_seq_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
    logic e;
  } lssc_pins_t;

  typedef struct packed {
    logic [4:0] step_code;
    logic af_counter_rst_off;
    logic autofocus_run_enable;
    logic dir;
    logic [2:0] hold_code;
    logic exc_12;
    logic home_en;
    logic plus64;
    logic [1:0] br_dir;
    logic br_en;
    logic [3:0] cur_code;
    lssc_seq_t seq;
    logic seq_home;
    logic [3:0] period_ms;
    logic [3:0] ms_left;
    logic [7:0] pulse_left;
    logic [2:0] phase;
    logic [7:0] rdata;
    lssc_pins_t pin_out;
    lssc_pins_t pin_oe;
    logic cc_mode;
    logic [8:0] cur_ma;
  } lssc_state_t;

endpackage : lssc_pkg

// [verilog/lssc_tick.sv]
`timescale 1ns/1ps

// =========================================================
// base tick prescaler, restartable so a sequence starts on a whole period
module lssc_tick #(
  parameter int CYCLES = 20000
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_restart,
  output logic o_tick
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || i_restart)
    begin
      cnt <= '0;
      o_tick <= 1'b0;
    end
    else if (cnt == LAST)
    begin
      cnt <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule : lssc_tick

// [bench/lssc_chk.sv]
`timescale 1ns/1ps

// =========================================================
// port checks on the device top
module lssc_chk
  import lssc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_coil_out_a,
  input wire logic o_coil_out_a_oe,
  input wire logic o_coil_out_b,
  input wire logic o_coil_out_c,
  input wire logic o_coil_or_shutter_out_d,
  input wire logic o_coil_or_shutter_out_d_oe,
  input wire logic o_shutter_out_e,
  input wire logic o_shutter_out_e_oe,
  input wire logic o_const_current_mode,
  input wire logic [3:0] o_current_code,
  input wire logic [8:0] o_current_ma,
  input wire logic o_sequence_busy_flag
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  wire busy = o_sequence_busy_flag;
  wire br_wr = i_wr_en && i_addr == ADDR_BRIDGE && !busy;

  a_busy_on_start: assert property (i_wr_en && i_addr == ADDR_STEP_CMD && !busy && i_wdata[1] |=> busy)
    else $error("busy not raised by start");
  a_coil_first_state: assert property ($rose(busy) |=> o_coil_out_a_oe &&
    {o_coil_out_a, o_coil_out_b, o_coil_out_c, o_coil_or_shutter_out_d} == 4'hA)
    else $error("wrong first coil state");
  a_coils_held_on: assert property (busy && $past(busy) |-> o_coil_out_a_oe && o_coil_or_shutter_out_d_oe)
    else $error("coils released in sequence");
  a_read_busy_bit: assert property (i_rd_en && i_addr == ADDR_SEQ_OPTS |=> o_rdata[7] == $past(busy))
    else $error("busy bit read wrong");
  a_current_set: assert property ($stable(o_current_code) |-> o_current_ma == 9'h104 - 9'h00A * o_current_code)
    else $error("current set point wrong");
  a_bridge_brake: assert property (br_wr && i_wdata[2:0] == 3'h7 |-> ##2 o_shutter_out_e_oe &&
    !o_shutter_out_e && !o_coil_or_shutter_out_d && !o_const_current_mode)
    else $error("brake not applied");
  a_bridge_standby: assert property (br_wr && !i_wdata[2] |-> ##2 !o_shutter_out_e_oe && !o_const_current_mode)
    else $error("bridge not in standby");
  a_const_current: assert property (!busy && !$past(busy) && o_const_current_mode |->
    o_shutter_out_e_oe && o_coil_or_shutter_out_d_oe && o_shutter_out_e != o_coil_or_shutter_out_d)
    else $error("regulation without conduction");

  c_start: cover property ($rose(busy));
  c_end: cover property ($fell(busy));
  c_conduct: cover property (o_const_current_mode);
endmodule : lssc_chk

// [bench/lssc_host.sv]
`timescale 1ns/1ps

// =========================================================
// host model: one register byte per strobe, held over one rising edge
module lssc_host (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // released lines show the inverse so a stale byte is never read as valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
  endtask : rd
endmodule : lssc_host

// [bench/lssc_top_tb.sv]
`timescale 1ns/1ps

// =========================================================
// bench top: host model, device and scoreboards
module lssc_top_tb;
  import lssc_pkg::*;
  localparam int TK = 4;
  localparam logic [31:0] PAT = 32'hA264_5198;
  localparam int HOLD_T [8] = '{1, 2, 4, 5, 8, 16, 32, 1};
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic wr_en, rd_en, a, a_oe, b, b_oe, c, c_oe, d, d_oe, e, e_oe, cc, busy, bo;
  logic rd_p = 1'b0;
  logic [1:0] bd;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] code;
  logic [8:0] ma;
  logic [3:0] last = 4'hF;
  logic [7:0] rd_q[$];
  logic [3:0] pat_q[$];
  int len_q[$];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int len = 0;
  int ex;
  logic [31:0] seed = 32'h0000_9FCC;

  initial forever #25 i_clk = ~i_clk;

  lssc_host i_host (.i_clk(i_clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

  lssc_top #(.TICK_CYCLES(TK)) i_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .o_coil_out_a(a), .o_coil_out_a_oe(a_oe), .o_coil_out_b(b), .o_coil_out_b_oe(b_oe),
    .o_coil_out_c(c), .o_coil_out_c_oe(c_oe), .o_coil_or_shutter_out_d(d), .o_coil_or_shutter_out_d_oe(d_oe),
    .o_shutter_out_e(e), .o_shutter_out_e_oe(e_oe), .o_const_current_mode(cc), .o_current_code(code),
    .o_current_ma(ma), .o_sequence_busy_flag(busy)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    total_checks++;
    if (x !== y)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", n, x, y);
    end
  endtask : chk

  task automatic finish_test;
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic rd(input logic [7:0] ad, input logic [7:0] x);
    rd_q.push_back(x);
    i_host.rd(ad);
  endtask : rd

  // =========================================================
  // monitors: read data, coil steps, sequence length
  always @(posedge i_clk)
    rd_p <= rd_en;

  always @(negedge i_clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_total++;
      finish_test;
    end
    if (rd_p)
      chk("rdata", {24'h0, rd_q.pop_front()}, {24'h0, rdata});
    if (a_oe !== 1'b1)
      last = 4'hF;
    else if ({a, b, c, d} !== last)
    begin
      last = {a, b, c, d};
      chk("coil", {28'h0, pat_q.pop_front()}, {28'h0, last});
    end
    if (a_oe === 1'b1)
      chk("coil_oe", 32'h0000_0007, {29'h0, b_oe, c_oe, d_oe});
    if (busy === 1'b1)
      len++;
    else if (len > 0)
    begin
      ex = len_q.pop_front();
      chk("seq_len", 1, len + 2 >= ex && len <= ex + TK + 2);
      chk("steps_left", 0, pat_q.size());
      len = 0;
    end
  end

  // =========================================================
  // one sequence; writes while busy must change nothing
  task automatic run(input logic home, exc, dir, input logic [2:0] hold, input logic [4:0] sc, input logic p64);
    int n;
    logic [2:0] ph;
    logic [2:0] st;
    logic [7:0] opt;
    n = 2 * sc + 2 + (p64 ? 64 : 0);
    st = exc ? 3'h1 : 3'h2;
    ph = 3'h0;
    opt = {2'h0, p64, home, exc, hold};
    len_q.push_back((2 * HOLD_T[hold] + n) * (home ? (exc ? 5 : 10) : (exc ? 1 : 2)) * TK);
    pat_q.push_back(PAT[31 -: 4]);
    repeat (n)
    begin
      ph = dir ? ph - st : ph + st;
      pat_q.push_back(PAT[31 - 4 * ph -: 4]);
    end
    i_host.wr(ADDR_SEQ_OPTS, opt);
    i_host.wr(ADDR_STEP_CMD, {sc, 1'b1, ~home, dir});
    rd(ADDR_SEQ_OPTS, {1'b1, opt[6:0]});
    i_host.wr(ADDR_STEP_CMD, 8'hFF);
    i_host.wr(ADDR_SEQ_OPTS, ~opt);
    while (busy === 1'b1) @(negedge i_clk);
    rd(ADDR_SEQ_OPTS, opt);
    rd(ADDR_STEP_CMD, {sc, 1'b1, ~home, dir});
  endtask : run

  initial
  begin
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    rd(ADDR_SEQ_OPTS, 8'h00);
    i_host.wr(ADDR_STEP_CMD, 8'hF8);
    rd(ADDR_SEQ_OPTS, 8'h00);
    rd(ADDR_STEP_CMD, 8'hF8);
    run(0, 0, 0, 3'h0, 5'h03, 0);
    run(0, 1, 1, 3'h3, 5'h02, 0);
    run(1, 1, 0, 3'h7, 5'h00, 1);
    run(1, 0, 1, 3'h2, 5'h1F, 0);
    run(0, 0, 0, 3'h6, 5'h1F, 1);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      bd = i[1:0];
      bo = i[2] && bd != 2'h0;
      i_host.wr(ADDR_BRIDGE, {5'h00, i[2:0]});
      i_host.wr(ADDR_CURRENT, seed[7:0]);
      rd(ADDR_BRIDGE, {5'h00, i[2:0]});
      rd(ADDR_CURRENT, {4'h0, seed[3:0]});
      rd(seed[15:8] | 8'h04, 8'h00);
      chk("bridge", {27'h0, bo, bo, bo & (bd == 2'h1), bo & (bd == 2'h2), bo & ^bd},
        {27'h0, d_oe, e_oe, d & d_oe, e & e_oe, cc});
      chk("current_ma", 32'h0000_0104 - 32'h0000_000A * seed[3:0], {23'h0, ma});
      chk("current_code", {28'h0, seed[3:0]}, {28'h0, code});
      chk("coil_idle", 32'h0000_0000, {29'h0, a_oe, b_oe, c_oe});
    end
    repeat (2) @(negedge i_clk);
    finish_test;
  end
endmodule : lssc_top_tb

bind lssc_top lssc_chk i_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_coil_out_a(o_coil_out_a), .o_coil_out_a_oe(o_coil_out_a_oe),
  .o_coil_out_b(o_coil_out_b), .o_coil_out_c(o_coil_out_c), .o_coil_or_shutter_out_d(o_coil_or_shutter_out_d),
  .o_coil_or_shutter_out_d_oe(o_coil_or_shutter_out_d_oe), .o_shutter_out_e(o_shutter_out_e),
  .o_shutter_out_e_oe(o_shutter_out_e_oe), .o_const_current_mode(o_const_current_mode),
  .o_current_code(o_current_code), .o_current_ma(o_current_ma), .o_sequence_busy_flag(o_sequence_busy_flag)
);
